// *** design/hsfc_pkg.sv ***
/*
   hsfc_pkg: constants and carrier types of the host serial flow control block.
   Assumes a single 250 MHz clock and byte-wide streams on both sides.
*/
package hsfc_pkg;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [7:0] XON_CHAR  = 8'h11;
   localparam logic       RST_GATE  = 1'b1;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } hsfc_byte_t;

   typedef struct packed {
      logic       start;  // packet preamble seen
      logic       done;   // packet fully received
      logic       good;   // packet check passed
   } hsfc_pkt_t;

   typedef enum logic [3:0] {
      CS_IDLE  = 4'b0001,
      CS_SENSE = 4'b0010,
      CS_RECV  = 4'b0100,
      CS_ACK   = 4'b1000
   } hsfc_cs_t;
endpackage : hsfc_pkg

// *** design/hsfc_sync.sv ***
/*
   hsfc_sync: two-stage synchroniser for pin-level inputs.
   Assumes the input may change at any time relative to sys_clk_i.
*/
`timescale 1ns/1ps
module hsfc_sync (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   input  wire logic clk_en_i,
   // level
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else if (clk_en_i) begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : hsfc_sync

// *** design/hsfc_flow.sv ***
/*
   hsfc_flow: flow control between the radio modem core and its terminal.
   Gates radio data towards the terminal, throttles the terminal by line or
   by character, and steers carrier sensing around incoming packets.
   Assumes an external uart; all byte ports are on sys_clk_i, rts pin async.
*/
`timescale 1ns/1ps
module hsfc_flow (
   // clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                clk_en_i,
   // configuration
   input  wire logic                sw_flow_i,     // 1: character scheme
   input  wire logic                ext_recv_i,    // extended receiving
   // terminal pins
   input  wire logic                rts_pin_i,
   output logic                     cts_pin_o,
   // bytes from terminal (uart receiver)
   input  wire hsfc_pkg::hsfc_byte_t term_rx_i,
   output hsfc_pkg::hsfc_byte_t     tx_buf_o,      // to radio transmit buffer
   // transmit buffer level
   input  wire logic                tx_near_full_i,
   // radio payload towards terminal
   input  wire hsfc_pkg::hsfc_byte_t radio_rx_i,
   output logic                     radio_rx_ready_o,
   // uart transmitter towards terminal
   output hsfc_pkg::hsfc_byte_t     term_tx_o,
   input  wire logic                term_tx_ready_i,
   // radio packet events and carrier sense control
   input  wire logic                tx_pending_i,
   input  wire hsfc_pkg::hsfc_pkt_t pkt_i,
   input  wire logic                cs_clear_i,
   output logic                     cs_active_o,
   output logic                     pkt_discard_o,
   output logic                     pkt_forward_o,
   output logic                     ack_send_o,
   output logic                     tx_go_o
);
   logic               rts_sync;
   logic               xoff_held;
   logic               near_q;
   logic               ctl_pend;
   logic [7:0]         ctl_char;
   hsfc_pkg::hsfc_cs_t cs_state;
   hsfc_pkg::hsfc_cs_t next_cs_state;

   hsfc_sync u_rts_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .async_i   (rts_pin_i),
      .sync_o    (rts_sync)
   );

   // only the selected scheme may stop delivery
   wire logic deliver_ok = sw_flow_i ? !xoff_held : rts_sync;
   wire logic is_xoff    = term_rx_i.valid && term_rx_i.data == hsfc_pkg::XOFF_CHAR;
   wire logic is_xon     = term_rx_i.valid && term_rx_i.data == hsfc_pkg::XON_CHAR;
   wire logic ctl_rx     = sw_flow_i && (is_xoff || is_xon);
   wire logic near_rise  = tx_near_full_i && !near_q;
   wire logic near_fall  = !tx_near_full_i && near_q;
   // control characters go out ahead of radio data
   wire logic ctl_go     = ctl_pend && term_tx_ready_i;
   wire logic ctl_set    = sw_flow_i && (near_rise || near_fall);
   // a byte is taken when the partner sees valid and ready together while term_tx_ready_i is also high
   wire logic data_go    = radio_rx_i.valid && radio_rx_ready_o && term_tx_ready_i;
   // ready drops one cycle ahead of a control character, so both never collide
   wire logic next_ready = deliver_ok && term_tx_ready_i && !ctl_set
                           && !(ctl_pend && !ctl_go);

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         xoff_held <= 1'b0;
      end else if (clk_en_i && sw_flow_i) begin
         if (is_xoff)
            xoff_held <= 1'b1;
         else if (is_xon)
            xoff_held <= 1'b0;
      end
   end

   // pending control character; a newer level change overrides an unsent one
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         near_q   <= 1'b0;
         ctl_pend <= 1'b0;
         ctl_char <= hsfc_pkg::XON_CHAR;
      end else if (clk_en_i) begin
         near_q <= tx_near_full_i;
         if (sw_flow_i && near_rise) begin
            ctl_pend <= 1'b1;
            ctl_char <= hsfc_pkg::XOFF_CHAR;
         end else if (sw_flow_i && near_fall) begin
            ctl_pend <= 1'b1;
            ctl_char <= hsfc_pkg::XON_CHAR;
         end else if (ctl_go || !sw_flow_i) begin
            ctl_pend <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cts_pin_o        <= hsfc_pkg::RST_GATE;
         term_tx_o        <= '0;
         tx_buf_o         <= '0;
         radio_rx_ready_o <= 1'b0;
      end else if (clk_en_i) begin
         // line stays on under character scheme so it never throttles
         cts_pin_o <= sw_flow_i ? 1'b1 : !tx_near_full_i;
         term_tx_o.valid <= ctl_go || data_go;
         term_tx_o.data  <= ctl_go ? ctl_char : radio_rx_i.data;
         // under character scheme control characters are consumed, not buffered
         tx_buf_o.valid  <= term_rx_i.valid && !ctl_rx;
         tx_buf_o.data   <= term_rx_i.data;
         radio_rx_ready_o <= next_ready;
      end
   end

   always_comb begin
      next_cs_state = cs_state;
      case (cs_state)
         hsfc_pkg::CS_IDLE:
            if (tx_pending_i)
               next_cs_state = hsfc_pkg::CS_SENSE;
         hsfc_pkg::CS_SENSE:
            if (pkt_i.start && ext_recv_i)
               next_cs_state = hsfc_pkg::CS_RECV;
            else if (pkt_i.start)
               next_cs_state = hsfc_pkg::CS_SENSE;
            else if (cs_clear_i)
               next_cs_state = hsfc_pkg::CS_IDLE;
         hsfc_pkg::CS_RECV:
            if (pkt_i.done)
               next_cs_state = pkt_i.good ? hsfc_pkg::CS_ACK : hsfc_pkg::CS_SENSE;
         hsfc_pkg::CS_ACK:
            next_cs_state = hsfc_pkg::CS_SENSE;
         default:
            next_cs_state = hsfc_pkg::CS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cs_state      <= hsfc_pkg::CS_IDLE;
         cs_active_o   <= 1'b0;
         pkt_discard_o <= 1'b0;
         pkt_forward_o <= 1'b0;
         ack_send_o    <= 1'b0;
         tx_go_o       <= 1'b0;
      end else if (clk_en_i) begin
         cs_state      <= next_cs_state;
         cs_active_o   <= next_cs_state == hsfc_pkg::CS_SENSE;
         pkt_discard_o <= cs_state == hsfc_pkg::CS_SENSE && pkt_i.start
                          && !ext_recv_i;
         pkt_forward_o <= cs_state == hsfc_pkg::CS_RECV && pkt_i.done && pkt_i.good;
         ack_send_o    <= cs_state == hsfc_pkg::CS_ACK;
         tx_go_o       <= cs_state == hsfc_pkg::CS_SENSE && !pkt_i.start && cs_clear_i;
      end
   end
endmodule : hsfc_flow

// *** testbench/hsfc_flow_checker.sv ***
/* hsfc_flow_checker: port-level assertions for hsfc_flow.
   Assumes clk_en_i held high and one clock domain. */
`timescale 1ns/1ps
module hsfc_flow_checker (
   // clock and reset
   input wire logic                 sys_clk_i,
   input wire logic                 reset_n_i,
   // watched ports
   input wire logic                 sw_flow_i,
   input wire logic                 ext_recv_i,
   input wire logic                 rts_pin_i,
   input wire logic                 cts_pin_o,
   input wire logic                 tx_near_full_i,
   input wire logic                 radio_rx_ready_o,
   input wire hsfc_pkg::hsfc_byte_t term_tx_o,
   input wire logic                 term_tx_ready_i,
   input wire hsfc_pkg::hsfc_pkt_t  pkt_i,
   input wire logic                 cs_active_o,
   input wire logic                 pkt_discard_o,
   input wire logic                 pkt_forward_o,
   input wire logic                 ack_send_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   AST_CTS_OFF: assert property (!sw_flow_i && tx_near_full_i |=> !cts_pin_o)
      else $error("cts high while buffer near full");
   AST_CTS_ON: assert property (!sw_flow_i && !tx_near_full_i |=> cts_pin_o)
      else $error("cts low while buffer has room");
   AST_CHAR_CTS: assert property (sw_flow_i |=> cts_pin_o)
      else $error("cts moved in character scheme");
   AST_RTS_GATE: assert property ((!sw_flow_i && !rts_pin_i)[*4] |-> !radio_rx_ready_o)
      else $error("radio data ready while request line low");
   AST_XOFF_OUT: assert property (sw_flow_i && $rose(tx_near_full_i) && term_tx_ready_i
      |-> ##[1:4] (term_tx_o.valid && term_tx_o.data == hsfc_pkg::XOFF_CHAR))
      else $error("stop character not sent");
   AST_XON_OUT: assert property (sw_flow_i && $fell(tx_near_full_i) && term_tx_ready_i
      |-> ##[1:4] (term_tx_o.valid && term_tx_o.data == hsfc_pkg::XON_CHAR))
      else $error("resume character not sent");
   AST_DISCARD: assert property (!ext_recv_i && cs_active_o && pkt_i.start |=> pkt_discard_o)
      else $error("packet during sensing not discarded");
   AST_KEEP: assert property (ext_recv_i && cs_active_o && pkt_i.start |=> !pkt_discard_o)
      else $error("packet discarded with extended receiving");
   AST_FWD_ACK: assert property (pkt_forward_o |-> ##[1:3] ack_send_o)
      else $error("forwarded packet not acknowledged");
endmodule : hsfc_flow_checker

bind hsfc_flow hsfc_flow_checker u_chk (.*);

// *** testbench/hsfc_term_model.sv ***
/* hsfc_term_model: terminal side, request line and byte sender.
   Assumes the bench picks payload bytes and when to send. */
`timescale 1ns/1ps
module hsfc_term_model (
   // clock
   input  wire logic           sys_clk_i,
   // control from bench and modem
   input  wire logic           cts_i,
   input  wire logic           rts_on_i,
   input  wire logic           send_i,
   input  wire logic [7:0]     byte_i,
   // towards modem
   output logic                rts_o,
   output hsfc_pkg::hsfc_byte_t rx_o
);
   initial rx_o = '0;
   initial rts_o = 1'b0;
   always @(posedge sys_clk_i) begin
      rts_o <= rts_on_i;
      rx_o.valid <= send_i && cts_i;
      // idle line alternates the last byte with its complement
      rx_o.data <= send_i ? byte_i : ~rx_o.data;
   end
endmodule : hsfc_term_model

// *** testbench/host_serial_flow_control_test.sv ***
/* host_serial_flow_control_test: scenarios for hsfc_flow.
   Assumes hsfc_term_model stands in for the terminal. */
`timescale 1ns/1ps
module host_serial_flow_control_test;
   logic clk, rst_n, sw, ext, near, ttr, pend, csc, rts_on, send, rts, cts, rdy;
   logic csa, disc, fwd, ack, go;
   logic [7:0] b, last, n_disc, n_fwd, n_ack, n_go, n_buf;
   hsfc_pkg::hsfc_byte_t radio, rx, tbuf, ttx;
   hsfc_pkg::hsfc_pkt_t  pkt;
   int fails, tests_run;
   hsfc_flow u_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .sw_flow_i(sw),
      .ext_recv_i(ext), .rts_pin_i(rts), .cts_pin_o(cts), .term_rx_i(rx), .tx_buf_o(tbuf),
      .tx_near_full_i(near), .radio_rx_i(radio), .radio_rx_ready_o(rdy), .term_tx_o(ttx),
      .term_tx_ready_i(ttr), .tx_pending_i(pend), .pkt_i(pkt), .cs_clear_i(csc),
      .cs_active_o(csa), .pkt_discard_o(disc), .pkt_forward_o(fwd), .ack_send_o(ack),
      .tx_go_o(go));
   hsfc_term_model u_term (.sys_clk_i(clk), .cts_i(cts), .rts_on_i(rts_on), .send_i(send),
      .byte_i(b), .rts_o(rts), .rx_o(rx));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ttx.valid) last <= ttx.data;
      if (radio.valid && rdy && ttr) radio.valid <= 1'b0;
      n_disc <= n_disc + disc;
      n_fwd <= n_fwd + fwd;
      n_ack <= n_ack + ack;
      n_go <= n_go + go;
      n_buf <= n_buf + tbuf.valid;
   end
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tsend(input logic [7:0] v);
      send <= 1'b1;
      b <= v; // bytes include the 11h and 13h control characters
      @(posedge clk);
      send <= 1'b0;
   endtask : tsend
   task t_line;
      near <= 1'b1; cyc(3); chk(cts, 8'h00);
      near <= 1'b0; cyc(3); chk(cts, 8'h01);
      rts_on <= 1'b0; cyc(6);
      radio <= {1'b1, 8'h5a}; cyc(8); chk(rdy, 8'h00);
      chk(last, 8'h00);
      rts_on <= 1'b1; cyc(8); chk(last, 8'h5a);
   endtask : t_line
   task t_char;
      sw <= 1'b1; cyc(2); chk(cts, 8'h01);
      near <= 1'b1; cyc(5); chk(last, hsfc_pkg::XOFF_CHAR);
      near <= 1'b0; cyc(5); chk(last, hsfc_pkg::XON_CHAR);
      tsend(hsfc_pkg::XOFF_CHAR); cyc(4); chk(rdy, 8'h00);
      radio <= {1'b1, 8'h3c}; cyc(6); chk(last, hsfc_pkg::XON_CHAR);
      tsend(hsfc_pkg::XON_CHAR); cyc(8); chk(last, 8'h3c);
      chk(n_buf, 8'h00);
      tsend(8'h42); cyc(3); chk(n_buf, 8'h01);
   endtask : t_char
   task t_sense;
      pend <= 1'b1; cyc(3); chk(csa, 8'h01);
      pkt <= 3'b100; @(posedge clk); pkt <= 3'b000; cyc(2); chk(n_disc, 8'h01);
      ext <= 1'b1; pkt <= 3'b100; @(posedge clk); pkt <= 3'b000; cyc(2);
      pkt <= 3'b011; @(posedge clk); pkt <= 3'b000; cyc(4);
      chk(n_disc, 8'h01); chk(n_fwd, 8'h01); chk(n_ack, 8'h01);
      csc <= 1'b1; cyc(3); chk(n_go, 8'h01);
   endtask : t_sense
   task summarize;
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      {rst_n, sw, ext, near, pend, csc, send, b, last} = '0;
      {n_disc, n_fwd, n_ack, n_go, n_buf, radio, pkt} = '0;
      {ttr, rts_on} = 2'b11;
      cyc(2);
      rst_n <= 1'b1;
      cyc(3);
      t_line();
      t_char();
      t_sense();
      summarize();
   end
endmodule : host_serial_flow_control_test
